// [bench/mode_select_monitor.sv]
`timescale 1ns/1ps
module mode_select_monitor
    import mode_select_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic cycle_strobe,
    input wire logic [15:0] control_word,
    input wire param_write_t param_wr,
    input wire logic error_clear,
    input wire logic [15:0] status_mode_word,
    input wire logic [SEL_W-1:0] active_sel,
    input wire logic switch_busy,
    input wire logic interface_error,
    input wire logic [MODE_W-1:0] active_mode_value
);
    // Selector as the controller places it in the control word
    wire [2:0] req = {control_word[11], control_word[9], control_word[8]};
    wire take = cycle_strobe && clk_en;
    logic [7:0] seen; // Parameters written since reset
    logic [2:0] last; // Selector of the previous telegram
    wire fresh = take && req != last;
    // Mirror of the write history, so uninitialised targets are known here
    always_ff @(posedge clock) begin
        if (rst) begin
            seen <= 8'h00;
            last <= 3'h0;
        end else begin
            if (clk_en && param_wr.en) seen[param_wr.sel] <= 1'b1;
            if (take) last <= req;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_status_mode_map: assert property (clk_en |=>
        status_mode_word == {5'h00, $past(active_sel), 8'h00}) else $error("status word off");
    a_hold_between_telegrams: assert property (!take |=> $stable(active_sel))
        else $error("active mode moved without telegram");
    a_change_on_strobe: assert property ($changed(active_sel) |-> $past(take))
        else $error("active mode changed off a strobe");
    a_old_until_done: assert property ($changed(active_sel) |-> $past(switch_busy))
        else $error("active mode changed without pending switch");
    a_busy_on_request: assert property (fresh && seen[req] && req != active_sel
        |=> switch_busy) else $error("switch not started");
    a_error_on_uninit: assert property (fresh && !seen[req] |=> interface_error)
        else $error("no error for uninitialised mode");
    a_uninit_no_switch: assert property (fresh && !seen[req] |=> $stable(active_sel))
        else $error("switched to uninitialised mode");
    a_error_sticky: assert property (interface_error && !error_clear |=> interface_error)
        else $error("error flag dropped on its own");
    a_reserved_zero: assert property (!active_mode_value[15] |->
        active_mode_value[14:10] == 5'h00) else $error("reserved bits set");
    c_switch_done: cover property ($changed(active_sel));
    c_error_raised: cover property ($rose(interface_error));
    c_request_seen: cover property (fresh && seen[req]);
endmodule : mode_select_monitor

bind drive_operation_mode_select mode_select_monitor u_mon (.clock, .rst, .clk_en,
    .cycle_strobe, .control_word, .param_wr, .error_clear, .status_mode_word,
    .active_sel, .switch_busy, .interface_error, .active_mode_value);

// [bench/motion_ctrl_model.sv]
`timescale 1ns/1ps
module motion_ctrl_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic [2:0] sel_req,
    input wire logic [3:0] gap,
    input wire logic [15:0] noise,
    output logic cycle_strobe,
    output logic [15:0] control_word
);
    logic [3:0] count; // Cycles left until the next telegram
    // One telegram per cycle, launched off the falling edge; gap sets the pace
    always @(negedge clock) begin
        if (rst || count == 4'h0) begin
            count <= gap;
            cycle_strobe <= !rst;
            // Other command bits refreshed every telegram, old and new mode alike
            control_word <= {noise[15:12], sel_req[2], noise[10], sel_req[1:0], noise[7:0]};
        end else begin
            count <= count - 4'h1;
            cycle_strobe <= 1'b0;
        end
    end
endmodule : motion_ctrl_model

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
    import mode_select_pkg::*;
    logic clock = 0, rst = 1, error_clear = 0, cycle_strobe, switch_busy, interface_error;
    logic [15:0] control_word, status_mode_word, param_rd_data, active_mode_value;
    logic [15:0] noise = 16'h0000, prev_status = 16'h0000, words[8], exp_q[$];
    logic [2:0] sel_req = 3'h0, param_rd_sel = 3'h0, active_sel;
    logic [3:0] gap = 4'h1;
    logic [31:0] rng = 32'h8;
    param_write_t param_wr = '0;
    mode_fields_t active_fields;
    int failures = 0, checks_done = 0, cycles = 0;
    drive_operation_mode_select DUT (.clock, .rst, .clk_en(1'b1), .cycle_strobe,
        .control_word, .param_wr, .param_rd_sel, .param_rd_data, .error_clear,
        .status_mode_word, .active_sel, .switch_busy, .interface_error,
        .active_mode_value, .active_fields);
    motion_ctrl_model partner (.clock, .rst, .sel_req, .gap, .noise, .cycle_strobe,
        .control_word);
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : next_rand
    // Expected decode: manufacturer words keep their code, standard ones the fields
    function automatic mode_fields_t fld(input logic [15:0] w);
        return w[15] ? {1'b1, w[14:0], 10'h000} : {16'h0000, w[9:0]};
    endfunction : fld
    task automatic check(input string what, input logic [15:0] expv, seen);
        checks_done++;
        if (seen !== expv) begin
            failures++;
            $display("Error %s expected %h seen %h", what, expv, seen);
        end
    endtask : check
    task automatic end_sim;
        if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    // Request a mode and wait for the acknowledgement; pace varies per switch
    task automatic switch_to(input logic [2:0] s);
        @(negedge clock);
        rng = next_rand(rng);
        gap = {2'h0, rng[1:0]} + 4'h1;
        noise = rng[31:16];
        sel_req = s;
        exp_q.push_back({5'h00, s, 8'h00});
        repeat (40) if (active_sel !== s) @(negedge clock);
        repeat (2) @(negedge clock);
        check("active_mode_value", words[s], active_mode_value);
        checks_done++;
        if (active_fields !== fld(words[s])) begin
            failures++;
            $display("Error active_fields expected %h seen %h", fld(words[s]), active_fields);
        end
    endtask : switch_to
    initial forever #25 clock = ~clock;
    // Hang guard sized well above the whole sequence
    always @(posedge clock) if (++cycles == 5000) begin
        failures++;
        end_sim();
    end
    // Every new status word must be the oldest acknowledgement still expected
    always @(posedge clock) begin
        #1;
        if (status_mode_word !== prev_status) begin
            prev_status = status_mode_word;
            if (exp_q.size() == 0) check("status_mode_word", 16'hFFFF, status_mode_word);
            else check("status_mode_word", exp_q.pop_front(), status_mode_word);
        end
    end
    initial begin
        repeat (3) @(negedge clock);
        rst = 0;
        check("interface_error", 16'h0000, {15'h0000, interface_error});
        // Fill every parameter but five; seven holds a manufacturer word
        for (int i = 0; i < 8; i++) begin
            rng = next_rand(rng);
            words[i] = (i == 5) ? 16'h0000 : (i == 7) ? (rng[15:0] | 16'h8000) : (rng[15:0] & 16'h03FF);
            @(negedge clock);
            // Parameter five is left unwritten so that it stays uninitialised
            param_wr = '{(i != 5), 3'(i), (i == 7) ? words[i] : (rng[15:0] & 16'h7FFF)};
            param_rd_sel = 3'(i);
            @(negedge clock);
            param_wr.en = (i == 5) ? 1'b0 : 1'b0;
            @(negedge clock);
            check("param_rd_data", words[i], param_rd_data);
        end
        foreach (words[k]) if (k == 5) words[k] = 16'h0000;
        switch_to(3'h1);
        switch_to(3'h2);
        switch_to(3'h3);
        switch_to(3'h4);
        switch_to(3'h6);
        switch_to(3'h7);
        switch_to(3'h0);
        // Uninitialised target: error, active mode kept
        @(negedge clock);
        sel_req = 3'h5;
        repeat (12) @(negedge clock);
        check("interface_error", 16'h0001, {15'h0000, interface_error});
        check("active_sel", 16'h0000, {13'h0000, active_sel});
        error_clear = 1;
        @(negedge clock);
        error_clear = 0;
        @(negedge clock);
        check("interface_error", 16'h0000, {15'h0000, interface_error});
        check("pending", 16'h0000, 16'(exp_q.size()));
        end_sim();
    end
endmodule : tb

// [hdl/drive_operation_mode_select.sv]
// Functional notes
// RL1: Mode choice comes from cyclic control word
// RL2: Selector sits in control bits 11, 9, 8
// RL3: Active mode reported in status bits 10..8
// RL4: Report updates in every drive state
// RL5: Acknowledge may lag several communication cycles
// RL6: Controller keeps all commands during switch
// RL7: After acknowledge only new-mode commands matter
// RL8: Uninitialised mode selection raises interface error
// RL9: Each mode held in its own parameter
// RL10: Modes four to seven use bits 11/10
// RL11: Bit 15 manufacturer flag, reserved bits zero
// RL12: Bit 9 means axis control word use
// RL13: Bit 8 means transition support
// RL14: Bits 7..4 expanded variant, bit 3 following
// RL15: Bits 2..0 carry the basic mode
// RL16: Old mode reported until switch completes
`timescale 1ns/1ps
module drive_operation_mode_select
    import mode_select_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    // Pulse once per communication cycle with a fresh master_data_telegram
    input wire logic cycle_strobe,
    // Cyclic control word of the master_data_telegram
    input wire logic [15:0] control_word,
    // Service side parameter access
    input wire param_write_t param_wr,
    input wire logic [SEL_W-1:0] param_rd_sel,
    output logic [MODE_W-1:0] param_rd_data,
    // Clears the sticky interface error
    input wire logic error_clear,
    // Mode bits for the acknowledge_telegram status word
    output logic [15:0] status_mode_word,
    output logic [SEL_W-1:0] active_sel,
    output logic switch_busy,
    output logic interface_error,
    output logic [MODE_W-1:0] active_mode_value,
    output mode_fields_t active_fields
);

    // Selector decoded from the control word
    wire logic [SEL_W-1:0] req_sel;
    // Word of the acknowledged mode, straight from the store
    wire logic [MODE_W-1:0] act_word;
    // Initialisation flags of all eight parameters
    wire logic [MODE_COUNT-1:0] init_flags;
    // Fields of the word currently held active
    mode_fields_t decoded;

    // Sequencer state and its next value
    switch_state_t state;
    switch_state_t next_state;
    // Target selector latched when a switch starts
    logic [SEL_W-1:0] target_sel;
    // Cycles left before the switch is acknowledged
    logic [3:0] cycle_count;
    // Selector last seen, used to spot a change
    logic [SEL_W-1:0] last_req;

    // Bit 11 is always decoded, so modes four to seven are reachable
    assign req_sel = {control_word[CTRL_SEL_HI],
                      control_word[CTRL_SEL_MID],
                      control_word[CTRL_SEL_LO]};  // [RL1] [RL2] [RL10]

    // A new request: a fresh telegram whose selector differs from the live one
    wire logic sel_change = cycle_strobe && (req_sel != last_req);
    // A valid target must have been initialised and differ from the active one
    wire logic target_ok = init_flags[req_sel];
    wire logic start_switch = sel_change && target_ok && (req_sel != active_sel);
    // Selecting a never-written parameter is an error, not a switch
    wire logic bad_select = sel_change && !target_ok;  // [RL8]
    // Completion when the last counted cycle passes
    wire logic switch_done = (state == ST_SWITCHING) && cycle_strobe
                           && (cycle_count == 4'h1);

    // Parameter storage for the eight mode words
    mode_param_store u_store (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .wr(param_wr),
        .rd_sel(param_rd_sel),
        .act_sel(active_sel),
        .rd_data(param_rd_data),
        .act_data(act_word),
        .initialised(init_flags)
    );

    // Field breakout of the active word
    mode_field_decoder u_decode (
        .value(active_mode_value),
        .fields(decoded)
    );

    // Next state of the switch sequencer
    always_comb begin
        next_state = state;
        case (state)
            ST_STEADY: begin
                if (start_switch) begin
                    next_state = ST_SWITCHING;
                end
            end
            ST_SWITCHING: begin
                // A fresh request restarts the count if it starts a new switch, else returns to steady without finishing
                if (sel_change) begin
                    next_state = start_switch ? ST_SWITCHING : ST_STEADY;
                end else if (switch_done) begin
                    next_state = ST_STEADY;
                end
            end
            default: begin
                next_state = ST_STEADY;
            end
        endcase
    end

    // Sequencer register
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= ST_STEADY;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // Track the requested selector once per telegram
    always_ff @(posedge clock) begin
        if (rst) begin
            last_req <= SEL_RESET;
        end else if (clk_en && cycle_strobe) begin
            last_req <= req_sel;
        end
    end

    // Count communication cycles of the switch; the lag is deliberate
    always_ff @(posedge clock) begin
        if (rst) begin
            target_sel <= SEL_RESET;
            cycle_count <= 4'h0;
        end else if (clk_en) begin
            if (start_switch) begin
                target_sel <= req_sel;
                cycle_count <= SWITCH_CYCLES;  // [RL5]
            end else if (state == ST_SWITCHING && cycle_strobe) begin
                cycle_count <= cycle_count - 4'h1;
            end
        end
    end

    // Active selector changes only at completion, so the old one stays reported
    always_ff @(posedge clock) begin
        if (rst) begin
            active_sel <= SEL_RESET;
        end else if (clk_en && switch_done && !sel_change) begin
            active_sel <= target_sel;  // [RL16] [RL9]
        end
    end

    // Latch the active word; no drive state gates this path
    always_ff @(posedge clock) begin
        if (rst) begin
            active_mode_value <= MODE_RESET;
            active_fields <= '0;
        end else if (clk_en) begin
            active_mode_value <= act_word;  // [RL4] [RL9]
            active_fields <= decoded;  // [RL11] [RL15]
        end
    end

    // Status word carries only the mode bits; others belong elsewhere
    always_ff @(posedge clock) begin
        if (rst) begin
            status_mode_word <= 16'h0000;
        end else if (clk_en) begin
            status_mode_word <= 16'h0000;
            status_mode_word[STAT_MODE_HI] <= active_sel[2];  // [RL3] [RL10]
            status_mode_word[STAT_MODE_MID] <= active_sel[1];  // [RL3]
            status_mode_word[STAT_MODE_LO] <= active_sel[0];  // [RL3] [RL4]
        end
    end

    // Busy while the controller must still serve both modes' commands
    always_ff @(posedge clock) begin
        if (rst) begin
            switch_busy <= 1'b0;
        end else if (clk_en) begin
            switch_busy <= (next_state == ST_SWITCHING);  // [RL6] [RL7]
        end
    end

    // Sticky error; a new event in the clear cycle wins
    always_ff @(posedge clock) begin
        if (rst) begin
            interface_error <= 1'b0;
        end else if (clk_en) begin
            if (bad_select) begin
                interface_error <= 1'b1;  // [RL8]
            end else if (error_clear) begin
                interface_error <= 1'b0;
            end
        end
    end

endmodule : drive_operation_mode_select

// [hdl/mode_field_decoder.sv]
`timescale 1ns/1ps
module mode_field_decoder
    import mode_select_pkg::*;
(
    input wire logic [MODE_W-1:0] value,
    output mode_fields_t fields
);

    // Standard fields are blanked for manufacturer modes
    wire logic is_manuf = value[FLD_MANUF];
    wire logic is_std = ~is_manuf;

    assign fields.manufacturer = is_manuf;  // [RL11]
    assign fields.manuf_code = is_manuf ? value[FLD_RSV_HI:0] : 15'h0000;
    assign fields.axis_ctrl = is_std & value[FLD_AXIS_CTRL];  // [RL12]
    assign fields.transition = is_std & value[FLD_TRANSITION];  // [RL13]
    assign fields.expanded = is_std ? value[FLD_EXP_HI:FLD_EXP_LO] : 4'h0;  // [RL14]
    assign fields.no_following_error = is_std & value[FLD_NO_FOLLOW];  // [RL14]
    assign fields.basic = is_std ? basic_mode_t'(value[FLD_BASIC_HI:FLD_BASIC_LO])
                                 : BASIC_NONE;  // [RL15]

endmodule : mode_field_decoder

// [hdl/mode_param_store.sv]
`timescale 1ns/1ps
module mode_param_store
    import mode_select_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire param_write_t wr,
    input wire logic [SEL_W-1:0] rd_sel,
    input wire logic [SEL_W-1:0] act_sel,
    output logic [MODE_W-1:0] rd_data,
    output logic [MODE_W-1:0] act_data,
    output logic [MODE_COUNT-1:0] initialised
);

    // One word per mode parameter, primary at index zero
    logic [MODE_W-1:0] mode_mem [MODE_COUNT];
    // Standard values get their reserved bits forced to zero
    logic [MODE_W-1:0] clean_data;

    assign clean_data = wr.data[FLD_MANUF] ? wr.data
                      : {wr.data[15], 5'h00, wr.data[9:0]};

    // Store words and remember which have been written since reset
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < MODE_COUNT; i++) begin
                mode_mem[i] <= MODE_RESET;
            end
            initialised <= INIT_RESET;
        end else if (clk_en && wr.en) begin
            mode_mem[wr.sel] <= clean_data;  // [RL9] [RL11]
            initialised[wr.sel] <= 1'b1;
        end
    end

    // Read back for the service side, registered
    always_ff @(posedge clock) begin
        if (rst) begin
            rd_data <= MODE_RESET;
        end else if (clk_en) begin
            rd_data <= mode_mem[rd_sel];
        end
    end

    // Active word follows the acknowledged selector combinationally
    assign act_data = mode_mem[act_sel];

endmodule : mode_param_store

// [hdl/mode_select_pkg.sv]
package mode_select_pkg;

    // Number of stored mode parameters: primary plus seven secondaries
    localparam int MODE_COUNT = 8;
    localparam int MODE_W = 16;
    localparam int SEL_W = 3;

    // Selector bit positions in the cyclic control word
    localparam int CTRL_SEL_HI = 11;
    localparam int CTRL_SEL_MID = 9;
    localparam int CTRL_SEL_LO = 8;

    // Actual mode bit positions in the drive status word
    localparam int STAT_MODE_HI = 10;
    localparam int STAT_MODE_MID = 9;
    localparam int STAT_MODE_LO = 8;

    // Field positions inside a stored mode value
    localparam int FLD_MANUF = 15;
    localparam int FLD_RSV_HI = 14;
    localparam int FLD_RSV_LO = 10;
    localparam int FLD_AXIS_CTRL = 9;
    localparam int FLD_TRANSITION = 8;
    localparam int FLD_EXP_HI = 7;
    localparam int FLD_EXP_LO = 4;
    localparam int FLD_NO_FOLLOW = 3;
    localparam int FLD_BASIC_HI = 2;
    localparam int FLD_BASIC_LO = 0;

    // Communication cycles the drive takes to acknowledge a mode switch
    localparam logic [3:0] SWITCH_CYCLES = 4'h2;

    // Reset values
    localparam logic [MODE_W-1:0] MODE_RESET = 16'h0000;
    localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
    localparam logic [MODE_COUNT-1:0] INIT_RESET = 8'h00;

    // Basic mode codes held in bits 2 to 0
    typedef enum logic [2:0] {
        BASIC_NONE = 3'h0,
        BASIC_TORQUE = 3'h1,
        BASIC_VELOCITY = 3'h2,
        BASIC_POS_FB1 = 3'h3,
        BASIC_POS_FB2 = 3'h4,
        BASIC_POS_FB12 = 3'h5,
        BASIC_PRESSURE = 3'h6,
        BASIC_NO_LOOPS = 3'h7
    } basic_mode_t;

    // Switch sequencer states
    typedef enum logic [1:0] {
        ST_STEADY = 2'h0,
        ST_SWITCHING = 2'h1
    } switch_state_t;

    // Decoded view of one stored mode value
    typedef struct packed {
        logic manufacturer;
        logic [14:0] manuf_code;
        logic axis_ctrl;
        logic transition;
        logic [3:0] expanded;
        logic no_following_error;
        basic_mode_t basic;
    } mode_fields_t;

    // Parameter write request from the service side
    typedef struct packed {
        logic en;
        logic [SEL_W-1:0] sel;
        logic [MODE_W-1:0] data;
    } param_write_t;

endpackage : mode_select_pkg
